// [design/sbst_pkg.sv]
// Package with constants and types for the SDRAM bank state tracker.
package sbst_pkg;
    localparam int SBST_BANKS = 4;
    localparam int SBST_CLK_PERIOD_NS = 8;
    // Timing figures in nanoseconds or cycles; plain defaults.
    localparam int SBST_PRECHARGE_PERIOD_NS = 20;
    localparam int SBST_ACTIVATE_TO_ACCESS_DELAY_NS = 20;
    localparam int SBST_REFRESH_CYCLE_PERIOD_NS = 66;
    localparam int SBST_MODE_LOAD_DELAY_CK = 2;
    localparam int SBST_BURST_LENGTH = 4;
    localparam int SBST_CAS_LATENCY = 2;
    // Least times round up to whole cycles.
    localparam int SBST_PRECHARGE_CYCLES =
        (SBST_PRECHARGE_PERIOD_NS + SBST_CLK_PERIOD_NS - 1)
        / SBST_CLK_PERIOD_NS;
    localparam int SBST_ACTIVATE_CYCLES =
        (SBST_ACTIVATE_TO_ACCESS_DELAY_NS + SBST_CLK_PERIOD_NS - 1)
        / SBST_CLK_PERIOD_NS;
    localparam int SBST_REFRESH_CYCLES =
        (SBST_REFRESH_CYCLE_PERIOD_NS + SBST_CLK_PERIOD_NS - 1)
        / SBST_CLK_PERIOD_NS;
    localparam int SBST_CNT_W = 8;

    typedef enum logic [2:0] {
        SBST_IDLE = 3'b000,
        SBST_ACTIVATING = 3'b001,
        SBST_ROW_ACTIVE = 3'b010,
        SBST_READ = 3'b011,
        SBST_WRITE = 3'b100,
        SBST_AUTO_PRE = 3'b101,
        SBST_PRECHARGING = 3'b110
    } sbst_bank_state_type;

    typedef enum logic [1:0] {
        SBST_DEV_NORMAL = 2'b00,
        SBST_DEV_REFRESH = 2'b01,
        SBST_DEV_MODE_LOAD = 2'b10,
        SBST_DEV_PRE_ALL = 2'b11
    } sbst_dev_state_type;

    // Command pins as the controller drives them; chip select and the three strobes are active low.
    typedef struct packed {
        logic chip_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_enable_n;
        logic [1:0] bank;
        logic auto_precharge;
    } sbst_cmd_type;
endpackage : sbst_pkg

// [design/sbst_tracker.sv]
// Bank and device state tracker for a four-bank SDRAM.
// Summary of operation
// - A bank is idle only after precharge and precharge_period elapse.
// - Row active follows activate plus activate_to_access_delay, no burst running.
// - Read state lasts from READ without auto precharge to burst end or cut.
// - Write state lasts from WRITE without auto precharge to burst end or cut.
// - PRECHARGE starts precharging; after precharge_period the bank is idle.
// - ACTIVE starts activating; after activate_to_access_delay it is row active.
// - Auto precharge access keeps bank busy for burst length plus precharge_period; then idle.
// - AUTO REFRESH lasts refresh_cycle_period, then all banks idle.
// - mode_register_load lasts mode_load_delay, then all banks idle.
// - PRECHARGE ALL lasts precharge_period, then every bank idle.
// - BURST TERMINATE ends the latest READ or WRITE burst, any bank.
// - PRECHARGE to an idle bank changes nothing.
// - Chip select high is inhibit; all strobes high is NOP.
// - Strobe codes LHH active, HLH read, HLL write, LHL precharge.
// - An interrupted auto precharge burst starts its precharge at interruption.
// - READ interrupting a READ takes over one CAS latency later.
module sbst_tracker
    import sbst_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire sbst_cmd_type cmd, // Command sampled each rising edge.
    output sbst_bank_state_type bank_state [SBST_BANKS], // Per bank state.
    output sbst_dev_state_type dev_state, // Device-wide operation.
    output logic all_idle // Every bank idle, no device operation.
);
    // Decoded commands.
    logic sel;
    logic is_active;
    logic is_read;
    logic is_write;
    logic is_pre;
    logic is_refresh;
    logic is_mode;
    logic is_term;
    logic pre_all;
    logic access;

    always_comb begin
        sel = !cmd.chip_select_n;
        is_active = sel && !cmd.row_strobe_n && cmd.column_strobe_n
            && cmd.write_enable_n;
        is_read = sel && cmd.row_strobe_n && !cmd.column_strobe_n
            && cmd.write_enable_n;
        is_write = sel && cmd.row_strobe_n && !cmd.column_strobe_n
            && !cmd.write_enable_n;
        is_pre = sel && !cmd.row_strobe_n && cmd.column_strobe_n
            && !cmd.write_enable_n;
        is_refresh = sel && !cmd.row_strobe_n && !cmd.column_strobe_n
            && cmd.write_enable_n;
        is_mode = sel && !cmd.row_strobe_n && !cmd.column_strobe_n
            && !cmd.write_enable_n;
        is_term = sel && cmd.row_strobe_n && cmd.column_strobe_n
            && !cmd.write_enable_n;
        // The auto precharge line doubles as the all-banks flag here.
        pre_all = is_pre && cmd.auto_precharge;
        access = is_read || is_write;
    end

    // Device-wide operation and its counter.
    sbst_dev_state_type next_dev_state;
    logic [SBST_CNT_W-1:0] dev_cnt;
    logic [SBST_CNT_W-1:0] next_dev_cnt;
    logic dev_busy;

    assign dev_busy = dev_state != SBST_DEV_NORMAL;

    always_comb begin
        next_dev_state = dev_state;
        next_dev_cnt = dev_cnt;
        if (dev_busy) begin
            // Commands are ignored here, including the ACTIVE the testbench sends during refresh.
            if (dev_cnt <= SBST_CNT_W'(1)) begin
                next_dev_state = SBST_DEV_NORMAL;
                next_dev_cnt = '0;
            end else begin
                next_dev_cnt = dev_cnt - SBST_CNT_W'(1);
            end
        end else if (is_refresh && all_idle) begin
            next_dev_state = SBST_DEV_REFRESH;
            next_dev_cnt = SBST_CNT_W'(SBST_REFRESH_CYCLES);
        end else if (is_mode && all_idle) begin
            next_dev_state = SBST_DEV_MODE_LOAD;
            next_dev_cnt = SBST_CNT_W'(SBST_MODE_LOAD_DELAY_CK);
        end else if (pre_all) begin
            next_dev_state = SBST_DEV_PRE_ALL;
            next_dev_cnt = SBST_CNT_W'(SBST_PRECHARGE_CYCLES);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dev_state <= SBST_DEV_NORMAL;
            dev_cnt <= '0;
        end else begin
            dev_state <= next_dev_state;
            dev_cnt <= next_dev_cnt;
        end
    end

    // Most recent burst owner, for burst terminate.
    logic [1:0] last_bank;
    logic [1:0] next_last_bank;

    always_comb begin
        next_last_bank = last_bank;
        if (access && !dev_busy) begin
            next_last_bank = cmd.bank;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_bank <= 2'h0;
        end else begin
            last_bank <= next_last_bank;
        end
    end

    // Per bank state machines.
    sbst_bank_state_type next_bank_state [SBST_BANKS];
    logic [SBST_CNT_W-1:0] bank_cnt [SBST_BANKS];
    logic [SBST_CNT_W-1:0] next_bank_cnt [SBST_BANKS];
    logic [SBST_BANKS-1:0] bank_idle;
    logic [SBST_BANKS-1:0] next_bank_idle;

    for (genvar b = 0; b < SBST_BANKS; b++) begin : g_bank
        logic hit;
        logic other_access;
        logic done;

        assign hit = !dev_busy && cmd.bank == 2'(b);
        assign other_access = !dev_busy && access && cmd.bank != 2'(b);
        assign done = bank_cnt[b] <= SBST_CNT_W'(1);
        assign next_bank_idle[b] = next_bank_state[b] == SBST_IDLE;

        always_comb begin
            next_bank_state[b] = bank_state[b];
            next_bank_cnt[b] = bank_cnt[b];
            if (!done) begin
                next_bank_cnt[b] = bank_cnt[b] - SBST_CNT_W'(1);
            end
            if (dev_state == SBST_DEV_PRE_ALL && dev_cnt <= SBST_CNT_W'(1))
            begin
                next_bank_state[b] = SBST_IDLE;
                next_bank_cnt[b] = '0;
            end else if (!dev_busy && pre_all) begin
                // Idle banks stay idle; the device timer rules the rest.
                if (bank_state[b] != SBST_IDLE) begin
                    next_bank_state[b] = SBST_PRECHARGING;
                    next_bank_cnt[b] = SBST_CNT_W'(SBST_PRECHARGE_CYCLES);
                end
            end else if (!dev_busy) begin
                unique case (bank_state[b])
                    SBST_IDLE: begin
                        if (hit && is_active) begin
                            next_bank_state[b] = SBST_ACTIVATING;
                            next_bank_cnt[b] =
                                SBST_CNT_W'(SBST_ACTIVATE_CYCLES);
                        end
                        // A precharge here is a no-operation.
                    end
                    SBST_ACTIVATING: begin
                        if (done) begin
                            next_bank_state[b] = SBST_ROW_ACTIVE;
                        end
                    end
                    SBST_PRECHARGING: begin
                        if (done) begin
                            next_bank_state[b] = SBST_IDLE;
                        end
                    end
                    SBST_AUTO_PRE: begin
                        // Burst length and the precharge run back to back in one timer.
                        if (done) begin
                            next_bank_state[b] = SBST_IDLE;
                        end else if (other_access && bank_cnt[b] >
                            SBST_CNT_W'(SBST_PRECHARGE_CYCLES)) begin
                            next_bank_cnt[b] =
                                SBST_CNT_W'(SBST_PRECHARGE_CYCLES);
                        end
                    end
                    SBST_ROW_ACTIVE, SBST_READ, SBST_WRITE: begin
                        if (hit && is_pre) begin
                            next_bank_state[b] = SBST_PRECHARGING;
                            next_bank_cnt[b] =
                                SBST_CNT_W'(SBST_PRECHARGE_CYCLES);
                        end else if (hit && access && cmd.auto_precharge)
                        begin
                            next_bank_state[b] = SBST_AUTO_PRE;
                            next_bank_cnt[b] = SBST_CNT_W'(
                                SBST_BURST_LENGTH + SBST_PRECHARGE_CYCLES);
                        end else if (hit && access) begin
                            next_bank_state[b] = is_read ? SBST_READ
                                : SBST_WRITE;
                            next_bank_cnt[b] = SBST_CNT_W'(SBST_BURST_LENGTH);
                        end else if (bank_state[b] == SBST_READ && !done
                            && other_access && is_read) begin
                            // The earlier read keeps the data bus for one
                            // CAS latency, so its burst ends that much later.
                            if (bank_cnt[b] >
                                SBST_CNT_W'(SBST_CAS_LATENCY)) begin
                                next_bank_cnt[b] =
                                    SBST_CNT_W'(SBST_CAS_LATENCY);
                            end
                        end else if (bank_state[b] != SBST_ROW_ACTIVE
                            && (done || other_access
                            || (is_term && last_bank == 2'(b)))) begin
                            // Burst finished, cut by another bank, or
                            // terminated.
                            next_bank_state[b] = SBST_ROW_ACTIVE;
                        end
                    end
                    default: begin
                        next_bank_state[b] = SBST_IDLE;
                    end
                endcase
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                bank_state[b] <= SBST_IDLE;
                bank_cnt[b] <= '0;
            end else begin
                bank_state[b] <= next_bank_state[b];
                bank_cnt[b] <= next_bank_cnt[b];
            end
        end
    end

    assign bank_idle = next_bank_idle;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            all_idle <= 1'b1;
        end else begin
            all_idle <= (&bank_idle) && next_dev_state == SBST_DEV_NORMAL;
        end
    end
endmodule // sbst_tracker

// [verif/sbst_ctrl_model.sv]
// Memory controller model that drives commands into the tracker.
module sbst_ctrl_model
    import sbst_pkg::*;
(
    input wire logic clk, // System clock.
    output sbst_cmd_type cmd // Command to the tracker.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cmd = 7'h38;
    // Strobe code in pin order chip select, row, column, write enable.
    // Clock enable counts as high on every edge here.
    // No data bus here, so no data mask precedes a cutting WRITE.
    task automatic send(input logic [3:0] code, input logic [1:0] bank,
        input logic ap);
        cmd = {code, bank, ap};
        @(posedge clk);
        #1;
    endtask
    // Idle edges keep busy banks untouched while their counts run.
    task automatic nops(input int n);
        repeat (n) send(4'h7, 2'h0, 1'b0);
    endtask
endmodule // sbst_ctrl_model

// [verif/sbst_tracker_properties.sv]
// Checker holding the timing properties of the bank state tracker.
module sbst_tracker_properties
    import sbst_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset_n, // Reset, active low.
    input wire sbst_cmd_type cmd, // Command bus.
    input wire sbst_bank_state_type bank_state [SBST_BANKS], // Banks.
    input wire sbst_dev_state_type dev_state, // Device operation.
    input wire logic all_idle // All idle flag.
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [3:0] c;
    logic ok;
    logic on0;
    sbst_bank_state_type s0;
    assign c = {cmd.chip_select_n, cmd.row_strobe_n,
        cmd.column_strobe_n, cmd.write_enable_n};
    assign ok = dev_state == SBST_DEV_NORMAL;
    assign on0 = ok && cmd.bank == 2'h0;
    assign s0 = bank_state[0];
    property p_activate;
        on0 && c == 4'h3 && s0 == SBST_IDLE |=>
            (s0 == SBST_ACTIVATING)[*3] ##1 s0 == SBST_ROW_ACTIVE;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activate timing wrong");
    property p_precharge;
        on0 && c == 4'h2 && !cmd.auto_precharge &&
            s0 inside {SBST_ROW_ACTIVE, SBST_READ, SBST_WRITE} |=>
            (s0 == SBST_PRECHARGING)[*3] ##1 s0 == SBST_IDLE;
    endproperty
    a_precharge: assert property (p_precharge)
        else $error("precharge timing wrong");
    property p_pre_idle;
        on0 && c == 4'h2 && !cmd.auto_precharge && s0 == SBST_IDLE
            |=> s0 == SBST_IDLE;
    endproperty
    a_pre_idle: assert property (p_pre_idle)
        else $error("precharge moved an idle bank");
    property p_pre_all;
        ok && c == 4'h2 && cmd.auto_precharge && !all_idle |=>
            (dev_state == SBST_DEV_PRE_ALL)[*3] ##1 all_idle;
    endproperty
    a_pre_all: assert property (p_pre_all)
        else $error("precharge all timing wrong");
    property p_refresh;
        ok && c == 4'h1 && all_idle |=>
            (dev_state == SBST_DEV_REFRESH && !all_idle)[*8]
            ##1 dev_state == SBST_DEV_REFRESH ##1 all_idle;
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh timing wrong");
    property p_mode;
        ok && c == 4'h0 && all_idle |=>
            (dev_state == SBST_DEV_MODE_LOAD)[*2] ##1 all_idle;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode load timing wrong");
    property p_read;
        on0 && c == 4'h5 && !cmd.auto_precharge &&
            s0 == SBST_ROW_ACTIVE ##1 (c == 4'h7)[*4] |->
            s0 == SBST_READ ##1 s0 == SBST_ROW_ACTIVE;
    endproperty
    a_read: assert property (p_read)
        else $error("read burst length wrong");
    property p_auto_pre;
        on0 && c[3:1] == 3'h2 && cmd.auto_precharge &&
            s0 == SBST_ROW_ACTIVE ##1 (c == 4'h7)[*7] |->
            s0 == SBST_AUTO_PRE ##1 s0 == SBST_IDLE;
    endproperty
    a_auto_pre: assert property (p_auto_pre)
        else $error("auto precharge timing wrong");
    property p_term;
        ok && c == 4'h6 && s0 == SBST_READ |=> s0 == SBST_ROW_ACTIVE;
    endproperty
    a_term: assert property (p_term)
        else $error("terminate left burst running");
endmodule // sbst_tracker_properties

bind sbst_tracker sbst_tracker_properties u_sbst_tracker_properties (
    .clk(clk), .reset_n(reset_n), .cmd(cmd), .bank_state(bank_state),
    .dev_state(dev_state), .all_idle(all_idle));

// [verif/sbst_tracker_tb.sv]
// Testbench for the SDRAM bank state tracker.
module sbst_tracker_tb
    import sbst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] act = 4'h3, rd = 4'h5, wr = 4'h4, pre = 4'h2;
    localparam logic [3:0] rfsh = 4'h1, mrs = 4'h0, term = 4'h6;
    logic clk = 0;
    logic reset_n = 0;
    sbst_cmd_type cmd;
    sbst_bank_state_type bs [SBST_BANKS];
    sbst_dev_state_type dev_state;
    logic all_idle;
    int failures = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    sbst_tracker u_sbst_tracker (.clk(clk), .reset_n(reset_n), .cmd(cmd),
        .bank_state(bs), .dev_state(dev_state), .all_idle(all_idle));
    sbst_ctrl_model u_sbst_ctrl_model (.clk(clk), .cmd(cmd));
    task automatic s(input logic [3:0] c, input logic [1:0] b, logic ap);
        u_sbst_ctrl_model.send(c, b, ap);
    endtask
    task automatic n(input int k);
        u_sbst_ctrl_model.nops(k);
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_activate;
        s(act, 0, 0);
        s(act, 1, 0);
        chk(bs[1], SBST_ACTIVATING);
        n(1);
        chk(bs[0], SBST_ACTIVATING);
        n(1);
        chk(bs[0], SBST_ROW_ACTIVE);
        n(1);
        chk(bs[1], SBST_ROW_ACTIVE);
        $display("activate done");
    endtask
    task automatic t_burst;
        s(rd, 0, 0);
        chk(bs[0], SBST_READ);
        s(term, 2, 0);
        chk(bs[0], SBST_ROW_ACTIVE);
        chk(bs[2], SBST_IDLE);
        s(wr, 1, 0);
        chk(bs[1], SBST_WRITE);
        s(rd, 0, 0);
        chk(bs[1], SBST_ROW_ACTIVE);
        n(3);
        chk(bs[0], SBST_READ);
        n(1);
        // The strobes spell a precharge; chip select high must mask it.
        s(4'hA, 1, 0);
        chk(bs[1], SBST_ROW_ACTIVE);
        chk({1'b0, dev_state}, {1'b0, SBST_DEV_NORMAL});
        s(rd, 0, 0);
        s(rd, 1, 0);
        chk(bs[0], SBST_READ);
        n(1);
        chk(bs[0], SBST_READ);
        n(1);
        chk(bs[0], SBST_ROW_ACTIVE);
        $display("burst done");
    endtask
    task automatic t_auto_pre;
        s(rd, 0, 1);
        s(rd, 1, 0);
        chk(bs[1], SBST_READ);
        n(2);
        chk(bs[0], SBST_AUTO_PRE);
        n(1);
        chk(bs[0], SBST_IDLE);
        s(pre, 0, 0);
        chk(bs[0], SBST_IDLE);
        s(act, 0, 0);
        n(3);
        s(wr, 0, 1);
        n(6);
        chk(bs[0], SBST_AUTO_PRE);
        n(1);
        chk(bs[0], SBST_IDLE);
        $display("auto precharge done");
    endtask
    task automatic t_precharge;
        s(act, 0, 0);
        n(3);
        s(pre, 0, 0);
        n(2);
        chk(bs[0], SBST_PRECHARGING);
        n(1);
        chk(bs[0], SBST_IDLE);
        s(pre, 0, 1);
        n(2);
        chk({1'b0, dev_state}, {1'b0, SBST_DEV_PRE_ALL});
        n(1);
        chk(bs[1], SBST_IDLE);
        chk({2'h0, all_idle}, 3'h1);
        $display("precharge done");
    endtask
    task automatic t_device;
        s(rfsh, 0, 0);
        chk({2'h0, all_idle}, 3'h0);
        s(act, 0, 0);
        n(7);
        chk({1'b0, dev_state}, {1'b0, SBST_DEV_REFRESH});
        n(1);
        chk(bs[0], SBST_IDLE);
        s(mrs, 0, 0);
        n(1);
        chk({1'b0, dev_state}, {1'b0, SBST_DEV_MODE_LOAD});
        n(1);
        chk({2'h0, all_idle}, 3'h1);
        s(act, 3, 0);
        s(rfsh, 0, 0);
        chk({1'b0, dev_state}, {1'b0, SBST_DEV_NORMAL});
        chk(bs[3], SBST_ACTIVATING);
        $display("device done");
    endtask
    // The tests need under 100 cycles; this bound leaves ample margin.
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1;
        chk({2'h0, all_idle}, 3'h1);
        t_activate();
        t_burst();
        t_auto_pre();
        t_precharge();
        t_device();
        end_sim();
    end
endmodule // sbst_tracker_tb
